// ### design/ebc_params.svh
// Constants for the external bus cycle control block.
// Assumes inclusion by bare name from design and bench files.
`ifndef EBC_PARAMS_SVH
`define EBC_PARAMS_SVH

`define EBC_ADDR_W 4
`define EBC_DATA_W 16

// Register offsets
`define EBC_OFS_MODE 4'h0
`define EBC_OFS_BCTL 4'h1
`define EBC_OFS_STAT 4'h2
`define EBC_OFS_CMD 4'h3

// Operating mode register fields
`define EBC_MODE_ATTR_PRIO_DIS 14
`define EBC_MODE_ACK_SYNC 15
`define EBC_MODE_RESET 16'h0000

// Bus control register fields
`define EBC_BCTL_WAIT_LO 0
`define EBC_BCTL_WAIT_W 5
`define EBC_BCTL_REQ_HOLD 8
`define EBC_BCTL_RESET 16'h001f

// Command register fields: attribute select, read/write
`define EBC_CMD_ATTR_LO 0
`define EBC_CMD_WRITE 4
`define EBC_CMD_DRAM 5

`endif

// ### design/ebc_pkg.sv
// Types for the external bus cycle control block.
// Assumes ebc_params.svh is compiled alongside.
package ebc_pkg;
	typedef enum logic [1:0] {
		EBC_ARB_SLAVE,
		EBC_ARB_WAIT_BUSY,
		EBC_ARB_MASTER
	} ebc_arb_state_t;

	typedef struct packed {
		logic [3:0] attr;
		logic write;
		logic dram;
	} ebc_cycle_t;

	typedef struct packed {
		logic [3:0] attr_o;
		logic [3:0] attr_oe_n;
		logic read_n;
		logic write_n;
		logic strobe_oe_n;
	} ebc_pins_t;
endpackage

// ### design/ebc_ack_sync.sv
// Transfer acknowledge qualifier: raw or two-stage synchronised.
// Assumes transfer_ack_n is synchronous when sync mode is selected.
`timescale 1ns/1ns
`default_nettype none
module ebc_ack_sync (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic async_mode_i,
	input wire logic transfer_ack_n_i,
	output logic ack_o
);
	logic meta;
	logic sync;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			meta <= 1'b1;
			sync <= 1'b1;
		end else if (clk_en_i) begin
			meta <= transfer_ack_n_i;
			sync <= meta;
		end
	end

	assign ack_o = async_mode_i ? ~sync : ~transfer_ack_n_i;
endmodule
`default_nettype wire

// ### design/ebc_attr_enc.sv
// Address attribute encoder: one-hot priority or free four-bit code.
// Assumes a combinational consumer.
`timescale 1ns/1ns
`default_nettype none
module ebc_attr_enc (
	input wire logic prio_dis_i,
	input wire logic [3:0] sel_i,
	output logic [3:0] attr_n_o
);
	logic [3:0] prio_hot;

	// Lowest index wins
	assign prio_hot = sel_i & (~sel_i + 4'h1);
	assign attr_n_o = prio_dis_i ? ~sel_i : ~prio_hot;
endmodule
`default_nettype wire

// ### design/ebc_top.sv
// External bus cycle control: strobes, attributes, wait states, arbitration.
// Assumes an on-chip host drives the register port synchronously.
// Function
// - One attribute line at a time, fixed priority
// - Priority disable drives four lines independently
// - Read strobe low only when master reading
// - Write strobe low only when master writing
// - Ignore acknowledge unless master in cycle
// - Deasserted acknowledge extends cycle without limit, except DRAM cycles or zero programmed wait
// - Finish cycle one clock after acknowledge
// - Wait count is longer of both
// - Acknowledge synchronous or asynchronous by mode
// - Request asserted while external bus needed
// - Request independent of master role
// - Hold bit keeps request asserted
// - Request only for external accesses
// - Reset deasserts request, arbitration to slave
// - Standby drops request unless hold set
// - After grant wait for busy release
// - Grant removal releases at cycle end
// - Master may park holding busy
`timescale 1ns/1ns
`default_nettype none
`include "ebc_params.svh"
module ebc_top (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic [`EBC_ADDR_W-1:0] reg_addr_i,
	input wire logic [`EBC_DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [`EBC_DATA_W-1:0] reg_rdata_o,
	input wire logic standby_i,
	input wire logic transfer_ack_n_i,
	input wire logic bus_grant_n_i,
	input wire logic bus_busy_n_i,
	output logic bus_busy_n_o,
	output logic bus_busy_oe_n_o,
	output logic bus_request_n_o,
	output logic [3:0] address_attribute_lines_o,
	output logic [3:0] address_attribute_lines_oe_n_o,
	output logic read_strobe_n_o,
	output logic write_strobe_n_o,
	output logic strobe_oe_n_o,
	output logic cycle_done_o
);
	logic [15:0] mode_reg;
	logic [15:0] bctl_reg;
	ebc_pkg::ebc_cycle_t pend;
	logic pend_valid;
	ebc_pkg::ebc_cycle_t cur;
	logic in_cycle;
	logic [`EBC_BCTL_WAIT_W-1:0] wait_cnt;
	logic ack_seen;
	logic req_n;
	ebc_pkg::ebc_arb_state_t arb_state;
	ebc_pkg::ebc_arb_state_t next_arb_state;
	ebc_pkg::ebc_pins_t pins;
	logic ack;
	logic [3:0] attr_n;
	logic [15:0] rdata_mux;

	////////////////////////////////////////////////////////////////////
	// Register port

	wire wr_mode = reg_wr_i & (reg_addr_i == `EBC_OFS_MODE);
	wire wr_bctl = reg_wr_i & (reg_addr_i == `EBC_OFS_BCTL);
	wire wr_cmd = reg_wr_i & (reg_addr_i == `EBC_OFS_CMD);
	wire prio_dis = mode_reg[`EBC_MODE_ATTR_PRIO_DIS];
	wire ack_async = ~mode_reg[`EBC_MODE_ACK_SYNC];
	wire req_hold = bctl_reg[`EBC_BCTL_REQ_HOLD];
	wire [`EBC_BCTL_WAIT_W-1:0] min_wait =
		bctl_reg[`EBC_BCTL_WAIT_LO +: `EBC_BCTL_WAIT_W];
	wire is_master = (arb_state == ebc_pkg::EBC_ARB_MASTER) & ~standby_i;
	// A removed grant ends the tenure; never open a cycle on the way out
	wire start = is_master & pend_valid & ~in_cycle & ~bus_grant_n_i;
	wire wait_done = (wait_cnt == '0);
	wire ack_ok = is_master & in_cycle & ack;
	// Zero programmed wait cannot stretch; DRAM ignores acknowledge
	wire ack_need = (min_wait != '0) & ~cur.dram;
	wire finish = in_cycle & wait_done & (~ack_need | ack_seen);

	assign rdata_mux =
		(reg_addr_i == `EBC_OFS_MODE) ? mode_reg :
		(reg_addr_i == `EBC_OFS_BCTL) ? bctl_reg :
		(reg_addr_i == `EBC_OFS_STAT) ?
			{11'h000, pend_valid, in_cycle, ~req_n, is_master, ack_seen} :
		16'h0000;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			mode_reg <= `EBC_MODE_RESET;
			bctl_reg <= `EBC_BCTL_RESET;
			reg_rdata_o <= 16'h0000;
		end else if (clk_en_i) begin
			if (wr_mode) begin
				mode_reg <= reg_wdata_i;
			end
			if (wr_bctl) begin
				bctl_reg <= reg_wdata_i;
			end
			reg_rdata_o <= reg_rd_i ? rdata_mux : 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Cycle engine

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			pend <= '0;
			pend_valid <= 1'b0;
			cur <= '0;
			in_cycle <= 1'b0;
			wait_cnt <= '0;
			ack_seen <= 1'b0;
			cycle_done_o <= 1'b0;
		end else if (clk_en_i) begin
			cycle_done_o <= finish;
			if (wr_cmd & ~pend_valid) begin
				pend.attr <= reg_wdata_i[`EBC_CMD_ATTR_LO +: 4];
				pend.write <= reg_wdata_i[`EBC_CMD_WRITE];
				pend.dram <= reg_wdata_i[`EBC_CMD_DRAM];
				pend_valid <= 1'b1;
			end else if (start) begin
				pend_valid <= 1'b0;
			end
			if (start) begin
				cur <= pend;
				in_cycle <= 1'b1;
				wait_cnt <= min_wait;
				ack_seen <= 1'b0;
			end else if (finish) begin
				in_cycle <= 1'b0;
			end else if (in_cycle) begin
				if (!wait_done) begin
					wait_cnt <= wait_cnt - 1'b1;
				end
				if (ack_ok) begin
					ack_seen <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Arbitration

	wire next_req_n = standby_i ? (req_hold ? req_n : 1'b1) :
		~(pend_valid | in_cycle | req_hold);

	always_comb begin
		next_arb_state = arb_state;
		unique case (arb_state)
			ebc_pkg::EBC_ARB_SLAVE: begin
				// Standby never competes for the bus
				if (!bus_grant_n_i && !req_n && !standby_i) begin
					next_arb_state = ebc_pkg::EBC_ARB_WAIT_BUSY;
				end
			end
			ebc_pkg::EBC_ARB_WAIT_BUSY: begin
				if (bus_grant_n_i) begin
					next_arb_state = ebc_pkg::EBC_ARB_SLAVE;
				end else if (bus_busy_n_i) begin
					next_arb_state = ebc_pkg::EBC_ARB_MASTER;
				end
			end
			ebc_pkg::EBC_ARB_MASTER: begin
				// Parked while granted
				if ((bus_grant_n_i && !in_cycle) || standby_i) begin
					next_arb_state = ebc_pkg::EBC_ARB_SLAVE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			arb_state <= ebc_pkg::EBC_ARB_SLAVE;
			req_n <= 1'b1;
		end else if (clk_en_i) begin
			arb_state <= next_arb_state;
			req_n <= next_req_n;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pins

	ebc_ack_sync u_ack (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.clk_en_i(clk_en_i),
		.async_mode_i(ack_async),
		.transfer_ack_n_i(transfer_ack_n_i),
		.ack_o(ack)
	);

	ebc_attr_enc u_attr (
		.prio_dis_i(prio_dis),
		.sel_i(cur.attr),
		.attr_n_o(attr_n)
	);

	// Strobes and attributes share one enable
	wire drive = is_master & ~reset_i;
	assign pins.attr_o = in_cycle ? attr_n : 4'hf;
	assign pins.attr_oe_n = {4{~drive}};
	assign pins.read_n = ~(drive & in_cycle & ~cur.write);
	assign pins.write_n = ~(drive & in_cycle & cur.write);
	assign pins.strobe_oe_n = ~drive;

	assign address_attribute_lines_o = pins.attr_o;
	assign address_attribute_lines_oe_n_o = pins.attr_oe_n;
	assign read_strobe_n_o = pins.read_n;
	assign write_strobe_n_o = pins.write_n;
	assign strobe_oe_n_o = pins.strobe_oe_n;
	assign bus_request_n_o = req_n;
	// Busy only ever pulled low; the outside pull-up returns it high
	assign bus_busy_n_o = 1'b0;
	assign bus_busy_oe_n_o = ~drive;

	////////////////////////////////////////////////////////////////////
	// Assertions

	AST_ONE_HOT: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(!prio_dis && !pins.attr_oe_n[0]) |-> $onehot0(~address_attribute_lines_o))
		else $error("more than one attribute line asserted");
	AST_APD: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(prio_dis && in_cycle) |-> (address_attribute_lines_o == ~cur.attr))
		else $error("attribute lines not independent");
	AST_RD: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!read_strobe_n_o |-> (is_master && in_cycle && !cur.write))
		else $error("read strobe outside master read");
	AST_WR: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!write_strobe_n_o |-> (is_master && in_cycle && cur.write))
		else $error("write strobe outside master write");
	AST_IGN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(clk_en_i && !ack_ok) |=> !$rose(ack_seen))
		else $error("acknowledge taken outside a cycle");
	AST_FIN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(clk_en_i && finish) |=> !in_cycle && cycle_done_o)
		else $error("cycle did not finish");
	AST_EXT: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(clk_en_i && in_cycle && ack_need && !ack_seen && !ack_ok) |=> in_cycle)
		else $error("cycle ended without acknowledge");
	AST_HOLD: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(clk_en_i && req_hold && !standby_i) |=> !bus_request_n_o)
		else $error("hold did not keep request");
	AST_SBY: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(clk_en_i && standby_i && !req_hold) |=> bus_request_n_o)
		else $error("standby kept request");
	AST_FLOAT: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!is_master |-> (strobe_oe_n_o && (&address_attribute_lines_oe_n_o)))
		else $error("pins driven while not master");

	// Cycle timing
	AST_MINW: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(clk_en_i && in_cycle && !wait_done) |=> in_cycle)
		else $error("cycle ended before programmed wait");
	AST_ACKEND: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(clk_en_i && ack_ok && ack_need && !ack_seen && wait_done) |=> finish)
		else $error("cycle not finishing after acknowledge");

	// Request and arbitration
	// No disable here: reset itself is the trigger
	AST_RST: assert property (@(posedge sys_clk_i)
		reset_i |=> (bus_request_n_o && arb_state == ebc_pkg::EBC_ARB_SLAVE))
		else $error("reset left request or mastership");
	AST_REQ: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(clk_en_i && !standby_i && pend_valid) |=> !bus_request_n_o)
		else $error("pending cycle without request");
	AST_EXTONLY: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(clk_en_i && !standby_i && !pend_valid && !in_cycle && !req_hold) |=> bus_request_n_o)
		else $error("request without external access");
	AST_BUSY: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(clk_en_i && arb_state != ebc_pkg::EBC_ARB_MASTER && !bus_busy_n_i) |=>
		(arb_state != ebc_pkg::EBC_ARB_MASTER))
		else $error("mastership taken while bus busy");
	AST_KEEP: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(clk_en_i && arb_state == ebc_pkg::EBC_ARB_MASTER && in_cycle && !standby_i) |=>
		(arb_state == ebc_pkg::EBC_ARB_MASTER))
		else $error("mastership lost inside a cycle");
	AST_LEAVE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(clk_en_i && arb_state == ebc_pkg::EBC_ARB_MASTER && bus_grant_n_i && !in_cycle) |=>
		(arb_state == ebc_pkg::EBC_ARB_SLAVE))
		else $error("mastership kept after grant removal");
	// Parked master keeps busy low between cycles
	AST_PARK: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		is_master |-> (!bus_busy_oe_n_o && !bus_busy_n_o))
		else $error("master not holding busy");
endmodule
`default_nettype wire

// ### bench/ebc_far_model.sv
// Far side of the bus: one arbiter, one rival master and a memory acknowledge.
// Assumes the device drives pins right after the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module ebc_far_model (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic bus_request_n_i,
	input wire logic bus_busy_n_i,
	input wire logic bus_busy_oe_n_i,
	input wire logic strobe_oe_n_i,
	input wire logic read_strobe_n_i,
	input wire logic write_strobe_n_i,
	input wire logic [4:0] ack_dly_i,
	output logic transfer_ack_n_o,
	output logic bus_grant_n_o,
	output logic bus_busy_n_o
);
	logic [1:0] rival_cnt;
	logic [4:0] ack_cnt;
	wire logic in_cyc = !strobe_oe_n_i && (!read_strobe_n_i || !write_strobe_n_i);
	// Pull-up on busy; the rival holds it a while after each new grant
	assign bus_busy_n_o = !bus_busy_oe_n_i ? bus_busy_n_i : (rival_cnt == 2'h0);
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			bus_grant_n_o <= 1'b1;
			rival_cnt <= 2'h0;
			ack_cnt <= 5'h00;
			transfer_ack_n_o <= 1'b1;
		end else begin
			// Grant follows request; removal asks the device to let go
			bus_grant_n_o <= bus_request_n_i;
			if (bus_grant_n_o && !bus_request_n_i)
				rival_cnt <= 2'h2;
			else if (rival_cnt != 2'h0)
				rival_cnt <= rival_cnt - 2'h1;
			ack_cnt <= in_cyc ? ack_cnt + 5'h01 : 5'h00;
			// Asserted once ack_dly_i strobe clocks have passed, raised again between cycles
			transfer_ack_n_o <= !(in_cyc && ack_cnt >= ack_dly_i);
		end
	end
endmodule
`default_nettype wire

// ### bench/external_bus_cycle_control_bench.sv
// Self-checking bench for the external bus cycle control block.
// Assumes the far side model above and a 20 MHz system clock.
`timescale 1ns/1ns
`default_nettype none
`include "ebc_params.svh"
module external_bus_cycle_control_bench;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic standby_i = 1'b0;
	logic [3:0] reg_addr_i = 4'h0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic [4:0] ack_dly = 5'h00;
	logic [15:0] rdata;
	logic ack_n, grant_n, busy_n, busy_o, busy_oe_n, req_n, rd_n, wr_n, st_oe_n, done;
	logic [3:0] attr, attr_oe_n, cur_sel;
	logic cur_wr = 1'b0;
	logic prio_dis = 1'b0;
	int error_cnt = 0;
	int total_checks = 0;
	int len = 0;
	int cyc = 0;
	int l0, l1;
	ebc_top i_ebc_top (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(1'b1),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .standby_i(standby_i),
		.transfer_ack_n_i(ack_n), .bus_grant_n_i(grant_n), .bus_busy_n_i(busy_n),
		.bus_busy_n_o(busy_o), .bus_busy_oe_n_o(busy_oe_n), .bus_request_n_o(req_n),
		.address_attribute_lines_o(attr), .address_attribute_lines_oe_n_o(attr_oe_n),
		.read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n), .strobe_oe_n_o(st_oe_n),
		.cycle_done_o(done));
	ebc_far_model i_ebc_far_model (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.bus_request_n_i(req_n), .bus_busy_n_i(busy_o), .bus_busy_oe_n_i(busy_oe_n),
		.strobe_oe_n_i(st_oe_n), .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n),
		.ack_dly_i(ack_dly), .transfer_ack_n_o(ack_n), .bus_grant_n_o(grant_n),
		.bus_busy_n_o(busy_n));
	initial begin
		forever #25 sys_clk_i = ~sys_clk_i;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			error_cnt++;
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [3:0] exp_attr(input logic pd, input logic [3:0] s);
		if (pd)
			return ~s;
		for (int i = 0; i < 4; i++)
			if (s[i])
				return ~(4'h1 << i);
		return 4'hf;
	endfunction
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge sys_clk_i);
		check("read data", e, rdata);
	endtask
	// One external cycle with a random selection; returns its strobe length
	task automatic run(input logic [4:0] d, output int l);
		int i;
		ack_dly <= d;
		cur_sel = 4'($urandom_range(1, 15));
		cur_wr = 1'($urandom_range(0, 1));
		len = 0;
		// DRAM bit kept clear: acknowledge stretching is used on every cycle
		wr(`EBC_OFS_CMD, {10'h000, 1'b0, cur_wr, cur_sel});
		i = 0;
		while (done !== 1'b1 && i < 300) begin
			@(negedge sys_clk_i);
			i++;
		end
		check("cycle finished", 16'h0001, 16'(i < 300));
		l = len;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Sampled on the falling edge, clear of the design's own updates
	always @(negedge sys_clk_i) begin
		cyc++;
		if (st_oe_n === 1'b0)
			check("busy driven while strobes driven", 16'h0000, 16'(busy_oe_n));
		if (busy_oe_n === 1'b0)
			check("busy level while master", 16'h0000, 16'(busy_o));
		check("attr enables", (st_oe_n === 1'b0) ? 16'h0000 : 16'h000f, 16'(attr_oe_n));
		if (!reset_i && st_oe_n === 1'b0 && (rd_n === 1'b0 || wr_n === 1'b0)) begin
			len++;
			check("read strobe", 16'(cur_wr), 16'(rd_n));
			check("write strobe", 16'(!cur_wr), 16'(wr_n));
			check("attribute lines", 16'(exp_attr(prio_dis, cur_sel)), 16'(attr));
		end
		if (cyc > 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(99));
		repeat (5) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rd(`EBC_OFS_MODE, `EBC_MODE_RESET);
		rd(`EBC_OFS_BCTL, `EBC_BCTL_RESET);
		rd(4'h5, 16'h0000);
		check("request after reset", 16'h0001, 16'(req_n));
		check("strobes float when slave", 16'h0001, 16'(st_oe_n));
		$display("test reset done");
		// Both acknowledge modes, both attribute schemes
		for (int m = 0; m < 4; m++) begin
			prio_dis = 1'(m);
			wr(`EBC_OFS_MODE, {1'(m >> 1), prio_dis, 14'h0000});
			wr(`EBC_OFS_BCTL, 16'h0006);
			run(5'h00, l0);
			run(5'h01, l1);
			check("minimum wait dominates", 16'(l0), 16'(l1));
			run(5'h0c, l0);
			run(5'h0d, l1);
			check("ack extends cycle", 16'(l0 + 1), 16'(l1));
			repeat (4) @(negedge sys_clk_i);
			check("request dropped when idle", 16'h0001, 16'(req_n));
			$display("test cycles mode %0d done", m);
		end
		wr(`EBC_OFS_BCTL, 16'h0106);
		repeat (4) @(negedge sys_clk_i);
		check("request held", 16'h0000, 16'(req_n));
		@(posedge sys_clk_i);
		standby_i <= 1'b1;
		repeat (3) @(negedge sys_clk_i);
		check("held request in standby", 16'h0000, 16'(req_n));
		check("strobes float in standby", 16'h0001, 16'(st_oe_n));
		wr(`EBC_OFS_BCTL, 16'h0006);
		repeat (3) @(negedge sys_clk_i);
		check("request in standby without hold", 16'h0001, 16'(req_n));
		@(posedge sys_clk_i);
		standby_i <= 1'b0;
		wr(`EBC_OFS_BCTL, 16'h0106);
		repeat (4) @(posedge sys_clk_i);
		reset_i <= 1'b1;
		repeat (2) @(negedge sys_clk_i);
		check("request in reset", 16'h0001, 16'(req_n));
		check("busy released in reset", 16'h0001, 16'(busy_oe_n));
		$display("test hold standby reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
